// ===== core/fis_consts.svh
// Register offsets, field positions, reset values and timing counts
`ifndef FIS_CONSTS_SVH
`define FIS_CONSTS_SVH

`define FIS_ADDR_W          8
`define FIS_OFF_STATUS      8'h00
`define FIS_OFF_EVENT       8'h04
`define FIS_OFF_MASK        8'h08
`define FIS_OFF_CTRL        8'h0C

`define FIS_STAT_FACTOR_LSB 0
`define FIS_STAT_VALID      6
`define FIS_STAT_REV        7
`define FIS_STAT_MODE_LSB   8
`define FIS_STAT_OUT_EN     11
`define FIS_STAT_RED        12

`define FIS_EV_FACTOR       0
`define FIS_EV_CONFIG       1
`define FIS_EV_PICKUP       2
`define FIS_EV_OVERLOAD     3
`define FIS_EV_ELEC         4
`define FIS_EV_W            5

`define FIS_CTRL_BLOCK      0

`define FIS_MASK_RST        5'h00
`define FIS_EVENT_RST       5'h00
`define FIS_CTRL_RST        1'h0

`define FIS_CLK_HZ          50000000
`define FIS_FLASH_HALF_MS   250
`define FIS_FLASH_HALF_CYCLES \
   (64'(`FIS_FLASH_HALF_MS) * 64'(`FIS_CLK_HZ) / 64'd1000)

`endif

// ===== core/fis_pkg.sv
// Types shared by the flow interpolator setup and status logic
package fis_pkg;
   typedef logic [5:0] fis_factor_t;
   typedef logic [3:0] fis_dial_t;
   typedef enum logic [2:0] {
      FIS_RUN    = 3'h0,
      FIS_NOSEL  = 3'h1,
      FIS_FAULT  = 3'h3,
      FIS_CONFIG = 3'h2,
      FIS_ELEC   = 3'h6
   } fis_mode_t;
endpackage : fis_pkg

// ===== core/fis_setup_status.sv
// Factor selection, direction reversal, status lamps and APB registers
//
// Operation
// - Dial 0..A maps to 1..32, B..F none
// - New factor reaches outputs without extra action
// - Factor may change anytime, no reset needed
// - Reverse switch swaps channels, inverts direction
// - Normal green steady; no factor green flashes
// - Configuration needed: all lamps on, outputs blocked
// - Pickup or interpolator fault lights red
// - Flow overload lights red
// - Electronics failure flashes all, outputs blocked
`timescale 1ns/100ps
`include "fis_consts.svh"
module fis_setup_status #(
   parameter int unsigned FLASH_HALF = 32'(`FIS_FLASH_HALF_CYCLES)
) (
   input  wire logic                     sys_clk,
   input  wire logic                     reset,
   input  wire logic [`FIS_ADDR_W-1:0]   paddr,
   input  wire logic                     psel,
   input  wire logic                     penable,
   input  wire logic                     pwrite,
   input  wire logic [31:0]              pwdata,
   output      logic [31:0]              prdata,
   output      logic                     pready,
   output      logic                     pslverr,
   input  wire fis_pkg::fis_dial_t       factor_selector_dial,
   input  wire logic                     direction_reverse_switch,
   input  wire logic                     config_required,
   input  wire logic                     pickup_fault,
   input  wire logic                     interpolator_fault,
   input  wire logic                     flow_overload,
   input  wire logic                     electronics_failure,
   input  wire logic                     chan_a_in,
   input  wire logic                     chan_b_in,
   input  wire logic                     dir_in,
   output      fis_pkg::fis_factor_t     interpolation_factor,
   output      logic                     factor_valid,
   output      logic                     chan_a_out,
   output      logic                     chan_b_out,
   output      logic                     direction_out,
   output      logic                     outputs_enable,
   output      logic                     lamp_yellow,
   output      logic                     lamp_green,
   output      logic                     lamp_red,
   output      logic                     irq
);
   import fis_pkg::*;

   function automatic fis_factor_t fis_decode(input fis_dial_t pos);
      case (pos)
         4'h0:    fis_decode = 6'h01;
         4'h1:    fis_decode = 6'h02;
         4'h2:    fis_decode = 6'h03;
         4'h3:    fis_decode = 6'h04;
         4'h4:    fis_decode = 6'h05;
         4'h5:    fis_decode = 6'h08;
         4'h6:    fis_decode = 6'h0A;
         4'h7:    fis_decode = 6'h0C;
         4'h8:    fis_decode = 6'h10;
         4'h9:    fis_decode = 6'h18;
         4'hA:    fis_decode = 6'h20;
         default: fis_decode = 6'h00;
      endcase
   endfunction : fis_decode

   fis_dial_t               dial_s;
   fis_dial_t               dial_prev;
   logic                    rev_s;
   logic                    cfg_s;
   logic                    pick_s;
   logic                    ipf_s;
   logic                    ovl_s;
   logic                    elec_s;
   logic [3:0]              lvl_prev;
   fis_mode_t               mode;
   fis_mode_t               next_mode;
   logic                    blocked;
   logic                    red_cond;
   logic [31:0]             flash_cnt;
   logic                    flash_phase;
   logic [`FIS_EV_W-1:0]    event_q;
   logic [`FIS_EV_W-1:0]    event_raw;
   logic [`FIS_EV_W-1:0]    mask;
   logic                    ctrl_block;
   logic                    wr_en;
   logic                    setup;

   // Dial, switch and fault pins cross into the clock domain here
   fis_sync #(
      .WIDTH (10)
   ) u_sync (
      .sys_clk  (sys_clk),
      .reset    (reset),
      .async_in ({factor_selector_dial, direction_reverse_switch,
                  config_required, pickup_fault, interpolator_fault,
                  flow_overload, electronics_failure}),
      .sync_out ({dial_s, rev_s, cfg_s, pick_s, ipf_s, ovl_s, elec_s})
   );

   // Factor follows the dial on the next edge, in any mode
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         interpolation_factor <= 6'h00;
         factor_valid         <= 1'b0;
      end else begin
         interpolation_factor <= fis_decode(dial_s);
         factor_valid         <= (fis_decode(dial_s) != 6'h00);
      end
   end

   assign red_cond = pick_s | ipf_s | ovl_s;

   always_comb begin
      if (elec_s)
         next_mode = FIS_ELEC;
      else if (cfg_s)
         next_mode = FIS_CONFIG;
      else if (red_cond)
         next_mode = FIS_FAULT;
      else if (fis_decode(dial_s) == 6'h00)
         next_mode = FIS_NOSEL;
      else
         next_mode = FIS_RUN;
   end

   always_ff @(posedge sys_clk) begin
      if (reset)
         mode <= FIS_RUN;
      else
         mode <= next_mode;
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         flash_cnt   <= 32'h0;
         flash_phase <= 1'b0;
      end else if (flash_cnt == FLASH_HALF - 32'd1) begin
         flash_cnt   <= 32'h0;
         flash_phase <= ~flash_phase;
      end else begin
         flash_cnt   <= flash_cnt + 32'd1;
      end
   end

   assign blocked = (mode == FIS_ELEC) || (mode == FIS_CONFIG)
                    || ctrl_block;

   // Signal path with optional reversal, silenced when blocked
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         chan_a_out     <= 1'b0;
         chan_b_out     <= 1'b0;
         direction_out  <= 1'b0;
         outputs_enable <= 1'b0;
      end else if (blocked) begin
         chan_a_out     <= 1'b0;
         chan_b_out     <= 1'b0;
         direction_out  <= 1'b0;
         outputs_enable <= 1'b0;
      end else begin
         chan_a_out     <= rev_s ? chan_b_in : chan_a_in;
         chan_b_out     <= rev_s ? chan_a_in : chan_b_in;
         direction_out  <= dir_in ^ rev_s;
         outputs_enable <= 1'b1;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         lamp_yellow <= 1'b0;
         lamp_green  <= 1'b0;
         lamp_red    <= 1'b0;
      end else begin
         case (mode)
            FIS_ELEC: begin
               lamp_yellow <= flash_phase;
               lamp_green  <= flash_phase;
               lamp_red    <= flash_phase;
            end
            FIS_CONFIG: begin
               lamp_yellow <= 1'b1;
               lamp_green  <= 1'b1;
               lamp_red    <= 1'b1;
            end
            FIS_FAULT: begin
               lamp_yellow <= 1'b0;
               lamp_green  <= factor_valid ? 1'b1 : flash_phase;
               lamp_red    <= 1'b1;
            end
            FIS_NOSEL: begin
               lamp_yellow <= 1'b0;
               lamp_green  <= flash_phase;
               lamp_red    <= 1'b0;
            end
            default: begin
               lamp_yellow <= 1'b0;
               lamp_green  <= 1'b1;
               lamp_red    <= 1'b0;
            end
         endcase
      end
   end

   // Sticky events: a new event wins over a write-one clear
   assign event_raw[`FIS_EV_FACTOR]   = (dial_s != dial_prev);
   assign event_raw[`FIS_EV_CONFIG]   = cfg_s & ~lvl_prev[0];
   assign event_raw[`FIS_EV_PICKUP]   = (pick_s | ipf_s) & ~lvl_prev[1];
   assign event_raw[`FIS_EV_OVERLOAD] = ovl_s & ~lvl_prev[2];
   assign event_raw[`FIS_EV_ELEC]     = elec_s & ~lvl_prev[3];

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         dial_prev <= 4'h0;
         lvl_prev  <= 4'h0;
      end else begin
         dial_prev <= dial_s;
         lvl_prev  <= {elec_s, ovl_s, pick_s | ipf_s, cfg_s};
      end
   end

   assign wr_en = psel & penable & pready & pwrite;
   assign setup = psel & ~penable;

   always_ff @(posedge sys_clk) begin
      if (reset)
         event_q <= `FIS_EVENT_RST;
      else if (wr_en && paddr == `FIS_OFF_EVENT)
         event_q <= (event_q & ~pwdata[`FIS_EV_W-1:0]) | event_raw;
      else
         event_q <= event_q | event_raw;
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         mask       <= `FIS_MASK_RST;
         ctrl_block <= `FIS_CTRL_RST;
      end else if (wr_en) begin
         if (paddr == `FIS_OFF_MASK)
            mask <= pwdata[`FIS_EV_W-1:0];
         if (paddr == `FIS_OFF_CTRL)
            ctrl_block <= pwdata[`FIS_CTRL_BLOCK];
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset)
         irq <= 1'b0;
      else
         irq <= |(event_q & mask);
   end

   // Answer one cycle after setup: zero wait states
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0;
      end else begin
         pready  <= setup;
         pslverr <= 1'b0;
         prdata  <= 32'h0;
         if (setup) begin
            case (paddr)
               `FIS_OFF_STATUS: begin
                  prdata[`FIS_STAT_FACTOR_LSB +: 6] <= interpolation_factor;
                  prdata[`FIS_STAT_VALID]           <= factor_valid;
                  prdata[`FIS_STAT_REV]             <= rev_s;
                  prdata[`FIS_STAT_MODE_LSB +: 3]   <= mode;
                  prdata[`FIS_STAT_OUT_EN]          <= outputs_enable;
                  prdata[`FIS_STAT_RED]             <= lamp_red;
               end
               `FIS_OFF_EVENT: prdata[`FIS_EV_W-1:0] <= event_q;
               `FIS_OFF_MASK:  prdata[`FIS_EV_W-1:0] <= mask;
               `FIS_OFF_CTRL:  prdata[`FIS_CTRL_BLOCK] <= ctrl_block;
               default:        pslverr <= 1'b1;
            endcase
         end
      end
   end

   property p_factor_apply;
      @(posedge sys_clk) disable iff (reset)
      $changed(dial_s) |=> interpolation_factor == fis_decode($past(dial_s));
   endproperty
   a_factor_apply: assert property (p_factor_apply)
      else $error("factor did not follow the dial");

   property p_factor_any_mode;
      @(posedge sys_clk) disable iff (reset)
      (elec_s || cfg_s || red_cond) && dial_s > 4'hA |=> !factor_valid;
   endproperty
   a_factor_any_mode: assert property (p_factor_any_mode)
      else $error("invalid dial position reported as valid");

   property p_factor_table;
      @(posedge sys_clk) disable iff (reset)
      dial_s == 4'hA ##1 dial_s == 4'hA |-> interpolation_factor == 6'h20;
   endproperty
   a_factor_table: assert property (p_factor_table)
      else $error("position A not decoded to 32");

   property p_reverse;
      @(posedge sys_clk) disable iff (reset)
      !blocked && rev_s |=> chan_a_out == $past(chan_b_in)
         && chan_b_out == $past(chan_a_in)
         && direction_out == !$past(dir_in) && outputs_enable;
   endproperty
   a_reverse: assert property (p_reverse)
      else $error("reversal not applied");

   property p_normal_lamps;
      @(posedge sys_clk) disable iff (reset)
      mode == FIS_RUN |=> lamp_green && !lamp_yellow && !lamp_red;
   endproperty
   a_normal_lamps: assert property (p_normal_lamps)
      else $error("normal operation lamps wrong");

   property p_config;
      @(posedge sys_clk) disable iff (reset)
      mode == FIS_CONFIG |=> lamp_yellow && lamp_green && lamp_red
         && !outputs_enable && !chan_a_out && !chan_b_out;
   endproperty
   a_config: assert property (p_config)
      else $error("configuration state not shown or not blocked");

   property p_fault_red;
      @(posedge sys_clk) disable iff (reset)
      !elec_s && !cfg_s && red_cond |=> ##1 lamp_red;
   endproperty
   a_fault_red: assert property (p_fault_red)
      else $error("fault did not light red");

   property p_elec;
      @(posedge sys_clk) disable iff (reset)
      mode == FIS_ELEC |=> lamp_red == $past(flash_phase)
         && lamp_yellow == lamp_red && lamp_green == lamp_red
         && !outputs_enable;
   endproperty
   a_elec: assert property (p_elec)
      else $error("electronics failure not flashed or not blocked");

   property p_priority;
      @(posedge sys_clk) disable iff (reset)
      elec_s |=> mode == FIS_ELEC;
   endproperty
   a_priority: assert property (p_priority)
      else $error("electronics failure lost its priority");

   c_elec: cover property (@(posedge sys_clk) disable iff (reset)
      mode == FIS_ELEC ##1 lamp_red);
   c_dial_change: cover property (@(posedge sys_clk) disable iff (reset)
      $changed(dial_s) ##1 factor_valid);
   c_reverse: cover property (@(posedge sys_clk) disable iff (reset)
      rev_s && outputs_enable);
   c_irq: cover property (@(posedge sys_clk) disable iff (reset)
      $rose(irq));
endmodule : fis_setup_status

// ===== core/fis_sync.sv
// Two-stage synchroniser for a group of pin inputs
`timescale 1ns/100ps
module fis_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             sys_clk,
   input  wire logic             reset,
   input  wire logic [WIDTH-1:0] async_in,
   output      logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] stage1;

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         stage1   <= '0;
         sync_out <= '0;
      end else begin
         stage1   <= async_in;
         sync_out <= stage1;
      end
   end
endmodule : fis_sync

// ===== test/fis_eval_model.sv
// Evaluation electronics model counting pulses on the channel A output
`timescale 1ns/100ps
module fis_eval_model (
   input  wire logic        sys_clk,
   input  wire logic        chan_a,
   input  wire logic        chan_b,
   input  wire logic        direction,
   output      int unsigned pulses
);
   logic last_a = 1'b0;
   initial pulses = 0;
   // Counts rising edges of channel A; B and direction are only observed
   always @(posedge sys_clk) begin
      if (chan_a === 1'b1 && last_a === 1'b0)
         pulses <= pulses + 1;
      last_a <= chan_a;
   end
endmodule : fis_eval_model

// ===== test/fis_setup_status_tb.sv
// Self-checking bench for the setup and status block
`timescale 1ns/100ps
`include "fis_consts.svh"
module fis_setup_status_tb;
   import fis_pkg::*;
   logic               sys_clk = 1'b0;
   logic               reset   = 1'b1;
   logic [7:0]         paddr   = 8'h00;
   logic               psel    = 1'b0;
   logic               penable = 1'b0;
   logic               pwrite  = 1'b0;
   logic [31:0]        pwdata  = 32'h0;
   logic [31:0]        prdata;
   logic               pready;
   logic               pslverr;
   fis_dial_t          dial    = 4'h0;
   logic               rev     = 1'b0;
   logic               cfg     = 1'b0;
   logic               pick    = 1'b0;
   logic               ipol    = 1'b0;
   logic               ovl     = 1'b0;
   logic               elec    = 1'b0;
   logic               a_in    = 1'b0;
   logic               b_in    = 1'b0;
   logic               d_in    = 1'b0;
   fis_factor_t        interpolation_factor;
   logic               factor_valid;
   logic               chan_a_out;
   logic               chan_b_out;
   logic               direction_out;
   logic               outputs_enable;
   logic               lamp_yellow;
   logic               lamp_green;
   logic               lamp_red;
   logic               irq;
   int unsigned        pulses;
   int                 fails   = 0;
   int                 checked = 0;
   logic [31:0]        r;
   logic               e;
   int                 hi;
   int                 same;
   int unsigned        p0;
   logic [5:0] fact [16] = '{6'h01, 6'h02, 6'h03, 6'h04, 6'h05, 6'h08,
      6'h0A, 6'h0C, 6'h10, 6'h18, 6'h20, 6'h00, 6'h00, 6'h00, 6'h00, 6'h00};
   wire  [2:0]         lamps = {lamp_yellow, lamp_green, lamp_red};

   always #10 sys_clk = ~sys_clk;

   fis_setup_status #(.FLASH_HALF(4)) fis_setup_status_i (
      .sys_clk(sys_clk), .reset(reset), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .factor_selector_dial(dial), .direction_reverse_switch(rev),
      .config_required(cfg), .pickup_fault(pick),
      .interpolator_fault(ipol), .flow_overload(ovl),
      .electronics_failure(elec), .chan_a_in(a_in), .chan_b_in(b_in),
      .dir_in(d_in), .interpolation_factor(interpolation_factor),
      .factor_valid(factor_valid), .chan_a_out(chan_a_out),
      .chan_b_out(chan_b_out), .direction_out(direction_out),
      .outputs_enable(outputs_enable), .lamp_yellow(lamp_yellow),
      .lamp_green(lamp_green), .lamp_red(lamp_red), .irq(irq));

   fis_eval_model fis_eval_model_i (
      .sys_clk(sys_clk), .chan_a(chan_a_out), .chan_b(chan_b_out),
      .direction(direction_out), .pulses(pulses));

   task check(input string what, input logic [31:0] seen, exp);
      checked++;
      if (seen !== exp) begin
         fails++;
         $display("CHECK FAILED %s exp %h seen %h", what, exp, seen);
      end
   endtask : check

   task tally_and_finish;
      $display("checks %0d mismatches %0d", checked, fails);
      if (fails == 0 && checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : tally_and_finish

   task apb(input logic [7:0] a, input logic w, input logic [31:0] d);
      int n;
      @(posedge sys_clk);
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      psel <= 1'b1;
      @(posedge sys_clk);
      penable <= 1'b1;
      n = 0;
      forever begin
         @(posedge sys_clk);
         n++;
         if (pready === 1'b1 || n > 20) break;
      end
      if (n > 20) fails++;
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task settle;
      repeat (8) @(posedge sys_clk);
   endtask : settle

   // Samples lamps for 16 cycles: green high count and cycles in unison
   task watch;
      hi = 0;
      same = 0;
      repeat (16) begin
         @(posedge sys_clk);
         hi += (lamp_green === 1'b1);
         same += (lamps === 3'b111 || lamps === 3'b000);
      end
   endtask : watch

   initial begin
      #100us;
      fails++;
      tally_and_finish();
   end

   initial begin
      repeat (16) @(posedge sys_clk);
      reset <= 1'b0;
      settle();
      for (int p = 0; p < 16; p++) begin
         @(posedge sys_clk);
         dial <= p[3:0];
         settle();
         check("factor", interpolation_factor, fact[p]);
         check("valid", factor_valid, p < 11);
         apb(`FIS_OFF_STATUS, 1'b0, 32'h0);
         check("status factor", r[5:0], fact[p]);
         watch();
         check("green steady", hi == 16, p < 11);
         check("yellow red", {lamp_yellow, lamp_red}, 2'b00);
      end
      $display("test dial table done");
      @(posedge sys_clk);
      dial <= 4'h6;
      a_in <= 1'b1;
      d_in <= 1'b1;
      settle();
      check("fwd", {chan_a_out, chan_b_out, direction_out}, 3'h5);
      rev <= 1'b1;
      settle();
      check("rev", {chan_a_out, chan_b_out, direction_out}, 3'h2);
      rev <= 1'b0;
      cfg <= 1'b1;
      pick <= 1'b1;
      dial <= 4'hB;
      settle();
      p0 = pulses;
      repeat (4) begin
         @(posedge sys_clk);
         a_in <= ~a_in;
      end
      settle();
      check("cfg lamps", lamps, 3'h7);
      check("cfg enable", outputs_enable, 1'b0);
      check("cfg pulses", pulses, p0);
      check("cfg valid", factor_valid, 1'b0);
      check("cfg factor", interpolation_factor, 6'h00);
      cfg <= 1'b0;
      pick <= 1'b0;
      dial <= 4'h6;
      for (int k = 0; k < 3; k++) begin
         @(posedge sys_clk);
         {pick, ipol, ovl} <= 3'h4 >> k;
         settle();
         check("fault lamps", lamps, 3'h3);
      end
      {pick, ipol, ovl} <= 3'h0;
      settle();
      check("run lamps", lamps, 3'h2);
      check("run enable", outputs_enable, 1'b1);
      $display("test switches and faults done");
      elec <= 1'b1;
      cfg <= 1'b1;
      settle();
      watch();
      check("elec unison", same, 16);
      check("elec flash", hi inside {[2:14]}, 1'b1);
      check("elec enable", outputs_enable, 1'b0);
      elec <= 1'b0;
      cfg <= 1'b0;
      $display("test electronics failure done");
      apb(`FIS_OFF_EVENT, 1'b1, 32'h1F);
      apb(`FIS_OFF_MASK, 1'b1, 32'h1);
      settle();
      check("irq idle", irq, 1'b0);
      dial <= 4'h2;
      settle();
      check("irq set", irq, 1'b1);
      apb(`FIS_OFF_EVENT, 1'b0, 32'h0);
      check("event", r[0], 1'b1);
      apb(`FIS_OFF_MASK, 1'b1, 32'h0);
      settle();
      check("irq masked", irq, 1'b0);
      apb(`FIS_OFF_MASK, 1'b1, 32'h1);
      apb(`FIS_OFF_EVENT, 1'b1, 32'h1);
      settle();
      check("irq clear", irq, 1'b0);
      apb(8'h10, 1'b0, 32'h0);
      check("unmapped err", e, 1'b1);
      check("unmapped data", r, 32'h0);
      apb(`FIS_OFF_CTRL, 1'b1, 32'h1);
      settle();
      check("ctrl block", outputs_enable, 1'b0);
      apb(`FIS_OFF_CTRL, 1'b0, 32'h0);
      check("ctrl read", r, 32'h1);
      apb(`FIS_OFF_CTRL, 1'b1, 32'h0);
      settle();
      check("ctrl release", outputs_enable, 1'b1);
      $display("test registers done");
      tally_and_finish();
   end
endmodule : fis_setup_status_tb
